// [logic/bsf_beacon_builder.v]
// beacon superframe and gts specification field builder
`timescale 1ns/1ps
`default_nettype none
`include "bsf_consts.vh"

// Function
// - The beacon order subfield of every superframe specification is written as zero.
// - The superframe order subfield of every superframe specification is written as zero.
// - The final contention access period slot subfield is written as zero.
// - The battery life extension bit is cleared in every beacon.
// - Association permit is forced to one under this profile, and follows software's permit bit otherwise.
// - The gts descriptor count of the gts specification is written as zero.
// - The gts permit bit of the gts specification is cleared.
// - No gts direction octet is ever emitted, so a beacon is three octets of fields only.
// - The receive enable output is the registered inverse of tx_active, so it is low in the cycle after each cycle of transmitting.
// - A beacon is built only on request, never from any periodic timer.
module bsf_beacon_builder #(
	parameter AW = 8,
	parameter DW = 32,
	parameter CW = 16
) (
	input wire clk,
	input wire rst_n,
	input wire [AW-1:0] reg_addr,
	input wire [DW-1:0] reg_wdata,
	input wire reg_we,
	input wire reg_re,
	output reg [DW-1:0] reg_rdata,
	input wire beacon_req,
	input wire tx_active,
	output wire [7:0] out_data,
	output wire out_last,
	output wire out_valid,
	input wire out_ready,
	output reg rx_enable,
	output reg busy,
	output reg beacon_done
);

	// builder states
	localparam ST_IDLE = 2'h0;
	localparam ST_SFS_LO = 2'h1;
	localparam ST_SFS_HI = 2'h2;
	localparam ST_GTS = 2'h3;

	// builder state and software control bits
	reg [1:0] state;
	reg [1:0] next_state;
	reg alt_profile;
	reg pan_coord;
	reg assoc_permit;

	// request flag, beacon count and field snapshots
	reg pending;
	reg [CW-1:0] count;
	reg [15:0] sfs;
	reg [15:0] last_sfs;

	// octet offered to the output buffer and the read mux result
	reg [7:0] push_data;
	reg push_last;
	reg push_valid;
	reg [DW-1:0] next_rdata;

	// handshakes and decoded strobes
	wire buf_in_ready;
	wire buf_out_valid_w;
	wire [8:0] buf_out;
	wire push_fire;
	wire ctrl_wr;
	wire cmd_wr;
	wire send_cmd;
	wire new_req;
	wire take_req;
	wire beacon_end;

	// offset match, shared by the write decodes
	function bsf_hit;
		input [AW-1:0] addr;
		input [7:0] offset;
		begin
			bsf_hit = (addr == offset);
		end
	endfunction

	// assemble a superframe specification from the live control bits
	function [15:0] bsf_make_sfs;
		input alt;
		input coord;
		input permit;
		reg [15:0] v;
		begin
			v = 16'h0000;
			v[`BSF_SFS_BO_LSB +: 4] = `BSF_BEACON_ORDER;
			v[`BSF_SFS_SO_LSB +: 4] = `BSF_SUPERFRAME_ORDER;
			v[`BSF_SFS_FINAL_LSB +: 4] = `BSF_FINAL_CAP_SLOT;
			v[`BSF_SFS_BLE] = `BSF_BATT_EXT;
			v[`BSF_SFS_RSVD] = 1'b0;
			v[`BSF_SFS_PAN_COORD] = coord;
			v[`BSF_SFS_ASSOC] = alt ? permit : `BSF_ASSOC_FIXED;
			bsf_make_sfs = v;
		end
	endfunction

	// gts specification octet from the descriptor count and permit it is given
	function [7:0] bsf_make_gts;
		input [2:0] desc_count;
		input permit;
		reg [7:0] g;
		begin
			g = 8'h00;
			g[`BSF_GTS_COUNT_LSB +: 3] = desc_count;
			g[`BSF_GTS_PERMIT] = permit;
			bsf_make_gts = g;
		end
	endfunction

	// status flags packed into their bits; the rest of the word reads zero
	function [3:0] bsf_status;
		input b;
		input tx;
		input rx;
		input pend;
		reg [3:0] s;
		begin
			s = 4'h0;
			s[`BSF_STAT_BUSY] = b;
			s[`BSF_STAT_TX_ACTIVE] = tx;
			s[`BSF_STAT_RX_ENABLE] = rx;
			s[`BSF_STAT_PENDING] = pend;
			bsf_status = s;
		end
	endfunction

	// write decode; writes to read-only or unmapped offsets are dropped
	assign ctrl_wr = reg_we && bsf_hit(reg_addr, `BSF_REG_CTRL);
	assign cmd_wr = reg_we && bsf_hit(reg_addr, `BSF_REG_CMD);
	assign send_cmd = cmd_wr && reg_wdata[`BSF_CMD_SEND];

	// a beacon is asked for only by the pin or the command, no timer stands behind it
	assign new_req = beacon_req || send_cmd;
	assign take_req = (state == ST_IDLE) && pending;
	assign beacon_end = (state == ST_GTS) && push_fire;

	// octet stream towards the output buffer
	assign push_fire = push_valid && buf_in_ready;
	assign out_data = buf_out[7:0];
	assign out_last = buf_out[8];
	assign out_valid = buf_out_valid_w;

	// control register; only software writes change the profile bits
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alt_profile <= 1'b0;
			pan_coord <= 1'b0;
			assoc_permit <= 1'b0;
		end else if (ctrl_wr) begin
			alt_profile <= reg_wdata[`BSF_CTRL_ALT_PROFILE];
			pan_coord <= reg_wdata[`BSF_CTRL_PAN_COORD];
			assoc_permit <= reg_wdata[`BSF_CTRL_ASSOC_PERMIT];
		end
	end

	// request flag: a new request in the cycle the old one is taken is kept, set wins
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pending <= 1'b0;
		end else if (new_req) begin
			pending <= 1'b1;
		end else if (take_req) begin
			pending <= 1'b0;
		end
	end

	// octet states advance only when the buffer takes the octet, so a stall loses nothing; idle leaves on pending alone
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (pending) begin
					next_state = ST_SFS_LO;
				end
			end
			ST_SFS_LO: begin
				if (push_fire) begin
					next_state = ST_SFS_HI;
				end
			end
			ST_SFS_HI: begin
				if (push_fire) begin
					next_state = ST_GTS;
				end
			end
			ST_GTS: begin
				if (push_fire) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// state register
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// snapshot the fields at request time so a mid-beacon control write cannot tear the octets
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sfs <= `BSF_SFS_RESET;
		end else if (take_req) begin
			sfs <= bsf_make_sfs(alt_profile, pan_coord, assoc_permit);
		end
	end

	// octet presented to the buffer, held until accepted
	always @* begin
		push_valid = 1'b0;
		push_data = 8'h00;
		push_last = 1'b0;
		case (state)
			ST_SFS_LO: begin
				push_valid = 1'b1;
				push_data = sfs[7:0];
			end
			ST_SFS_HI: begin
				push_valid = 1'b1;
				push_data = sfs[15:8];
			end
			ST_GTS: begin
				push_valid = 1'b1;
				push_data = bsf_make_gts(`BSF_GTS_COUNT, `BSF_GTS_PERMIT_VAL);
				push_last = 1'b1;
			end
			default: begin
				push_valid = 1'b0;
			end
		endcase
	end

	// completed beacons; the count wraps and software takes differences
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= {CW{1'b0}};
		end else if (beacon_end) begin
			count <= count + {{(CW-1){1'b0}}, 1'b1};
		end
	end

	// last superframe specification handed to the buffer, readable by software
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_sfs <= `BSF_SFS_RESET;
		end else if (beacon_end) begin
			last_sfs <= sfs;
		end
	end

	// pulse once the last octet has entered the buffer, which may be before it leaves
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			beacon_done <= 1'b0;
		end else begin
			beacon_done <= beacon_end;
		end
	end

	// receiver stays on unless the transmit path was active in the previous cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_enable <= 1'b1;
		end else begin
			rx_enable <= ~tx_active;
		end
	end

	// busy covers the builder and any octet still waiting in the buffer
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
		end else begin
			busy <= (next_state != ST_IDLE) || buf_out_valid_w;
		end
	end

	// read mux; anything but a read of a mapped offset gives zero
	always @* begin
		next_rdata = {DW{1'b0}};
		if (reg_re) begin
			case (reg_addr)
				`BSF_REG_CTRL: begin
					next_rdata[`BSF_CTRL_ALT_PROFILE] = alt_profile;
					next_rdata[`BSF_CTRL_PAN_COORD] = pan_coord;
					next_rdata[`BSF_CTRL_ASSOC_PERMIT] = assoc_permit;
				end
				`BSF_REG_STATUS: begin
					next_rdata[3:0] = bsf_status(busy, tx_active, rx_enable, pending);
				end
				`BSF_REG_COUNT: begin
					next_rdata[CW-1:0] = count;
				end
				`BSF_REG_LAST_SFS: begin
					next_rdata[15:0] = last_sfs;
				end
				default: begin
					next_rdata = {DW{1'b0}};
				end
			endcase
		end
	end

	// read data register, valid one cycle after the strobe and zero otherwise
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= {DW{1'b0}};
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// output buffer, the receiver may stall at any octet
	bsf_skid_buffer #(
		.WIDTH(9)
	) u_buf (
		.clk(clk),
		.rst_n(rst_n),
		.in_data({push_last, push_data}),
		.in_valid(push_valid),
		.in_ready(buf_in_ready),
		.out_data(buf_out),
		.out_valid(buf_out_valid_w),
		.out_ready(out_ready),
		.full()
	);

endmodule // bsf_beacon_builder

`default_nettype wire

// [logic/bsf_consts.vh]
// constants for the beacon superframe field builder
`ifndef BSF_CONSTS_VH
`define BSF_CONSTS_VH

// register offsets (byte addresses)
`define BSF_REG_CTRL 8'h00
`define BSF_REG_CMD 8'h04
`define BSF_REG_STATUS 8'h08
`define BSF_REG_COUNT 8'h0c
`define BSF_REG_LAST_SFS 8'h10

// control register fields
`define BSF_CTRL_ALT_PROFILE 0
`define BSF_CTRL_PAN_COORD 1
`define BSF_CTRL_ASSOC_PERMIT 2
`define BSF_CTRL_RESET 3'h0

// command register fields
`define BSF_CMD_SEND 0

// status register fields
`define BSF_STAT_BUSY 0
`define BSF_STAT_TX_ACTIVE 1
`define BSF_STAT_RX_ENABLE 2
`define BSF_STAT_PENDING 3

// superframe specification layout
`define BSF_SFS_BO_LSB 0
`define BSF_SFS_SO_LSB 4
`define BSF_SFS_FINAL_LSB 8
`define BSF_SFS_BLE 12
`define BSF_SFS_RSVD 13
`define BSF_SFS_PAN_COORD 14
`define BSF_SFS_ASSOC 15

// fixed subfield values under this profile
`define BSF_BEACON_ORDER 4'h0
`define BSF_SUPERFRAME_ORDER 4'h0
`define BSF_FINAL_CAP_SLOT 4'h0
`define BSF_BATT_EXT 1'h0
`define BSF_ASSOC_FIXED 1'h1

// gts specification layout and values
`define BSF_GTS_COUNT_LSB 0
`define BSF_GTS_PERMIT 7
`define BSF_GTS_COUNT 3'h0
`define BSF_GTS_PERMIT_VAL 1'h0

// other reset values
`define BSF_COUNT_RESET 16'h0000
`define BSF_SFS_RESET 16'h0000

`endif

// [logic/bsf_skid_buffer.v]
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module bsf_skid_buffer #(
	parameter WIDTH = 9
) (
	input wire clk,
	input wire rst_n,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output reg [WIDTH-1:0] out_data,
	output reg out_valid,
	input wire out_ready,
	output wire full
);

	reg [WIDTH-1:0] skid_data;
	reg skid_valid;

	// second entry only fills while the head is stalled, so accepting is safe whenever it is empty
	assign in_ready = ~skid_valid;
	assign full = skid_valid & out_valid;

	// head and skid entries
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_data <= {WIDTH{1'b0}};
			out_valid <= 1'b0;
			skid_data <= {WIDTH{1'b0}};
			skid_valid <= 1'b0;
		end else if (in_valid && in_ready) begin
			if (out_valid && !out_ready) begin
				skid_data <= in_data;
				skid_valid <= 1'b1;
			end else begin
				out_data <= in_data;
				out_valid <= 1'b1;
			end
		end else if (out_ready) begin
			if (skid_valid) begin
				out_data <= skid_data;
				skid_valid <= 1'b0;
			end else begin
				out_valid <= 1'b0;
			end
		end
	end

endmodule // bsf_skid_buffer

`default_nettype wire

// [testbench/bsf_chk_sva.sv]
// assertions on the beacon field builder ports
`timescale 1ns/1ps
`default_nettype none
module bsf_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [31:0] reg_rdata,
	input wire logic beacon_req,
	input wire logic tx_active,
	input wire logic [7:0] out_data,
	input wire logic out_last,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic rx_enable,
	input wire logic busy,
	input wire logic beacon_done
);
	logic [1:0] idx;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// octet position in a beacon, so each octet is judged by its place
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			idx <= 2'h0;
		else if (out_valid && out_ready)
			idx <= out_last ? 2'h0 : idx + 2'h1;
	end
	a_rx_follow: assert property (rx_enable == !$past(tx_active)) else $error("rx enable");
	a_lo_zero: assert property (out_valid && idx == 2'h0 |-> out_data == 8'h00) else $error("sfs low");
	a_hi_fields: assert property (out_valid && idx == 2'h1 |-> out_data[5:0] == 6'h00) else $error("sfs high");
	a_last_place: assert property (out_valid |-> out_last == (idx == 2'h2)) else $error("octet count");
	a_gts_zero: assert property (out_valid && out_last |-> out_data == 8'h00) else $error("gts spec");
	a_stall_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("stall");
	a_idle_quiet: assert property ((!out_valid && !busy && !beacon_req && !reg_we) [*3] |=> !out_valid)
		else $error("unasked beacon");
	a_done_pulse: assert property (beacon_done |-> out_valid ##1 !beacon_done) else $error("done pulse");
	a_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata == 32'h0) else $error("read data");
	c_stall: cover property (out_valid && !out_ready);
	c_last: cover property (out_valid && out_ready && out_last);
	c_tx: cover property (tx_active && !rx_enable);
endmodule // bsf_chk
bind bsf_beacon_builder bsf_chk i_chk (.clk(clk), .rst_n(rst_n), .reg_we(reg_we), .reg_re(reg_re),
	.reg_rdata(reg_rdata), .beacon_req(beacon_req), .tx_active(tx_active), .out_data(out_data),
	.out_last(out_last), .out_valid(out_valid), .out_ready(out_ready), .rx_enable(rx_enable), .busy(busy),
	.beacon_done(beacon_done));
`default_nettype wire

// [testbench/bsf_sink.sv]
// receiver model for the beacon octet stream
`timescale 1ns/1ps
`default_nettype none
module bsf_sink (
	input wire logic clk,
	input wire logic stall,
	input wire logic [7:0] out_data,
	input wire logic out_last,
	input wire logic out_valid,
	output logic out_ready
);
	logic [8:0] q[$];
	// a stall must leave every word waiting in the buffer
	assign out_ready = !stall;
	// keep each accepted octet with its last flag
	always @(posedge clk) begin
		if (out_valid && out_ready)
			q.push_back({out_last, out_data});
	end
endmodule // bsf_sink
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the beacon field builder
`timescale 1ns/1ps
`default_nettype none
`include "bsf_consts.vh"
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic beacon_req = 1'b0;
	logic tx_active = 1'b0;
	logic stall = 1'b0;
	wire [31:0] reg_rdata;
	wire [7:0] out_data;
	wire out_last, out_valid, out_ready, rx_enable, busy, beacon_done;
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	int dn = 0;
	int k;
	logic [31:0] ctl_t[5] = '{32'h0, 32'h3, 32'h5, 32'h2, 32'h4};
	logic [7:0] hi_t[5] = '{8'h80, 8'h40, 8'h80, 8'hc0, 8'h80};
	always #10 clk = ~clk;
	bsf_beacon_builder i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .beacon_req(beacon_req),
		.tx_active(tx_active), .out_data(out_data), .out_last(out_last), .out_valid(out_valid),
		.out_ready(out_ready), .rx_enable(rx_enable), .busy(busy), .beacon_done(beacon_done));
	bsf_sink i_snk (.clk(clk), .stall(stall), .out_data(out_data), .out_last(out_last),
		.out_valid(out_valid), .out_ready(out_ready));
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask
	task rd(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		#1 chk(n, e, reg_rdata);
	endtask
	task req;
		@(posedge clk);
		beacon_req <= 1'b1;
		@(posedge clk);
		beacon_req <= 1'b0;
	endtask
	// wait for one whole beacon, bounded, then compare its three octets
	task bcn(input logic [7:0] hi);
		for (int i = 0; i < 60 && i_snk.q.size() < 3; i++)
			@(posedge clk);
		chk("beacon", {9'h000, 1'b0, hi, 9'h100}, {i_snk.q[0], i_snk.q[1], i_snk.q[2]});
		repeat (3) if (i_snk.q.size() > 0) void'(i_snk.q.pop_front());
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// completion pulses, one per beacon
	always @(posedge clk)
		if (beacon_done === 1'b1)
			dn++;
	// a hang counts as a mismatch
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			fails++;
			summarize;
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd("ctrl", `BSF_REG_CTRL, 32'h0);
		rd("status", `BSF_REG_STATUS, 32'h4);
		rd("count", `BSF_REG_COUNT, 32'h0);
		rd("unmapped", 8'h20, 32'h0);
		$display("test reset done");
		// odd settings ask by command, even ones by the request pin
		for (k = 0; k < 5; k++) begin
			wr(`BSF_REG_CTRL, ctl_t[k]);
			if (k[0])
				wr(`BSF_REG_CMD, 32'h1);
			else
				req;
			bcn(hi_t[k]);
		end
		rd("last sfs", `BSF_REG_LAST_SFS, 32'h8000);
		$display("test fields done");
		// stalled receiver; the two later requests merge into one
		@(posedge clk) stall <= 1'b1;
		req;
		repeat (10) @(posedge clk);
		req;
		req;
		repeat (10) @(posedge clk);
		#1 chk("held", 32'h1, {31'h0, out_valid});
		rd("status busy", `BSF_REG_STATUS, 32'hd);
		@(posedge clk) stall <= 1'b0;
		bcn(8'h80);
		bcn(8'h80);
		repeat (20) @(posedge clk);
		chk("extra", 32'h0, i_snk.q.size());
		rd("count", `BSF_REG_COUNT, 32'h7);
		chk("done pulses", 32'h7, dn);
		$display("test stall done");
		// transmitting closes the receive path
		@(posedge clk) tx_active <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk("rx off", 32'h0, {31'h0, rx_enable});
		rd("status tx", `BSF_REG_STATUS, 32'h2);
		@(posedge clk) tx_active <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("rx on", 32'h1, {31'h0, rx_enable});
		$display("test rx done");
		summarize;
	end
endmodule // tb
`default_nettype wire
